/* imba_master.sv */
`timescale 1ns/1ps
// Functional notes
// - Buffer write during a Stop sets write collision; buffer unchanged.
// - In sleep, slave address match or byte wakes CPU if enabled.
// - Reset disables the port and ends any bus transfer.
// - Start-seen and Stop-seen clear on reset or port disable.
// - Stop seen while idle, as after a collision, sets the event flag.
// - Sending a 1 with SCL high, SDA low means collision; go idle.
// - Arbitration checked in address, data, Start, Restart and Ack phases.
// - Byte collision halts transfer, clears buffer full, frees both lines.
// - Sequence collision aborts it, frees lines, clears its enable bit.
// - Buffer write after collision transmits from the first data bit.
// - SDA or SCL low at Start begin: abort, flag collision, idle.
// - Start counts with SDA high; SCL low meanwhile is a collision.
// - SDA low during first Start count: pull SDA early, no collision.
// - SDA high at count end: pull SDA, count ignoring SCL, pull SCL.
// - Restart: free SDA, count, free SCL, sample SDA once SCL high.
// - Restart count: SDA fall is fine; SCL fall with SDA high collides.
// - Both high at Restart timeout: pull SDA, count, then pull SCL.
// - Stop: SDA low, free SCL, count when high, SDA low at end collides.
// - Stop: SCL low before SDA released is a collision.
// - Stop: SDA high with SCL high marks Stop-seen; period later done.
module imba_master #(
   parameter int RATE_W = imba_pkg::RATE_W,
   parameter int DATA_W = imba_pkg::DATA_W
) (
   input  wire logic              CLOCK_IN,       // System clock
   input  wire logic              RST_IN,         // Async reset
   input  wire logic              LINK_CLK_IN,    // Bus sampling clock
   input  wire logic              SDA_IN,         // Data line level
   output logic                   SDA_OUT,        // Data drive level
   output logic                   SDA_OE_OUT,     // Pull data low
   input  wire logic              SCL_IN,         // Clock line level
   output logic                   SCL_OUT,        // Clock drive level
   output logic                   SCL_OE_OUT,     // Pull clock low
   input  wire logic              PORT_EN_IN,     // Port enable
   input  wire logic [RATE_W-1:0] RATE_RELOAD_IN, // Rate reload value
   input  wire logic              START_REQ_IN,   // Start request
   input  wire logic              RESTART_REQ_IN, // Restart request
   input  wire logic              STOP_REQ_IN,    // Stop request
   input  wire logic              ACK_REQ_IN,     // Ack sequence request
   input  wire logic              ACK_DATA_IN,    // Ack bit to send
   input  wire logic              BUF_WR_IN,      // Buffer write strobe
   input  wire logic [DATA_W-1:0] BUF_DATA_IN,    // Buffer write data
   input  wire logic              EVT_CLR_IN,     // Clear event flag
   input  wire logic              WRITE_COLLISION_FLAG_CLR_IN,    // Clear write collision
   input  wire logic              BCOL_CLR_IN,    // Clear bus collision
   input  wire logic              SLEEP_IN,       // CPU asleep
   input  wire logic              EVT_IE_IN,      // Event irq enable
   input  wire logic              SLV_EVT_IN,     // Slave match or byte
   output logic                   START_EN_OUT,   // Start in progress
   output logic                   RESTART_EN_OUT, // Restart in progress
   output logic                   STOP_EN_OUT,    // Stop in progress
   output logic                   ACK_EN_OUT,     // Ack in progress
   output logic                   BUF_FULL_OUT,   // Buffer full
   output logic                   ACK_STAT_OUT,   // Slave ack sampled
   output logic                   WRITE_COL_OUT,  // Write collision
   output logic                   BUS_COL_OUT,    // Bus collision
   output logic                   SERIAL_EVT_OUT, // Serial event flag
   output logic                   START_SEEN_OUT, // Start seen
   output logic                   STOP_SEEN_OUT,  // Stop seen
   output logic                   WAKE_OUT,       // Wake pulse
   output logic                   IDLE_OUT        // Engine idle
);
   imba_pkg::imba_state_t state_q;
   imba_pkg::imba_state_t state_d;
   logic [RATE_W-1:0]     brg_q;
   logic [RATE_W-1:0]     brg_d;
   logic [DATA_W-1:0]     shift_q;
   logic [DATA_W-1:0]     shift_d;
   logic [imba_pkg::BIT_W-1:0] bit_q;
   logic [imba_pkg::BIT_W-1:0] bit_d;
   logic                  sda_drv_q;
   logic                  sda_drv_d;
   logic                  scl_drv_q;
   logic                  scl_drv_d;
   logic                  sen_q;
   logic                  sen_d;
   logic                  restart_enable_bit_q;
   logic                  restart_enable_bit_d;
   logic                  pen_q;
   logic                  pen_d;
   logic                  ack_sequence_enable_bit_q;
   logic                  ack_sequence_enable_bit_d;
   logic                  bf_q;
   logic                  bf_d;
   logic                  ackst_q;
   logic                  ackst_d;
   logic                  write_collision_flag_q;
   logic                  write_collision_flag_d;
   logic                  bcol_q;
   logic                  bcol_d;
   logic                  evt_q;
   logic                  evt_d;
   logic                  sseen_q;
   logic                  sseen_d;
   logic                  pseen_q;
   logic                  pseen_d;
   logic                  wake_q;
   logic                  idle_q;
   logic                  port_en_q;
   logic                  drive_zero_q;
   logic                  col;
   logic [1:0]            sda_sync_q;
   logic [1:0]            scl_sync_q;
   logic [2:0]            stt_sync_q;
   logic [2:0]            stp_sync_q;

   imba_mon_if mon_bus ();

   imba_bus_monitor u_mon (
      .link_clk_in (LINK_CLK_IN),
      .rst_in      (RST_IN),
      .sda_in      (SDA_IN),
      .scl_in      (SCL_IN),
      .mon         (mon_bus.mon)
   );

   function automatic logic [RATE_W-1:0] count_down(
      input logic [RATE_W-1:0] v
   );
      count_down = (v == '0) ? v : v - RATE_W'(1);
   endfunction

   function automatic logic pull_for(input logic data_bit);
      pull_for = ~data_bit;
   endfunction

   wire sda_s      = sda_sync_q[1];
   wire scl_s      = scl_sync_q[1];
   wire brg_zero   = (brg_q == '0);
   wire start_evt  = stt_sync_q[2] ^ stt_sync_q[1];
   wire stop_evt   = stp_sync_q[2] ^ stp_sync_q[1];
   wire in_idle    = (state_q == imba_pkg::ST_IDLE);
   wire sending_1  = ~sda_drv_q;
   wire lost_arb   = sending_1 & ~sda_s;
   wire ack_slot   = (bit_q == imba_pkg::ACK_SLOT);
   wire last_data  = (bit_q == imba_pkg::LAST_DATA);
   wire wr_refused = BUF_WR_IN & ~in_idle;
   wire wr_taken   = BUF_WR_IN & in_idle & PORT_EN_IN;
   wire [DATA_W-1:0] shift_next = {shift_q[DATA_W-2:0], 1'b0};

   assign mon_bus.port_en = port_en_q;

   always_comb begin
      state_d   = state_q;
      brg_d     = count_down(brg_q);
      shift_d   = shift_q;
      bit_d     = bit_q;
      sda_drv_d = sda_drv_q;
      scl_drv_d = scl_drv_q;
      sen_d     = sen_q;
      restart_enable_bit_d    = restart_enable_bit_q;
      pen_d     = pen_q;
      ack_sequence_enable_bit_d   = ack_sequence_enable_bit_q;
      bf_d      = bf_q;
      ackst_d   = ackst_q;
      col       = 1'b0;
      write_collision_flag_d    = (write_collision_flag_q & ~WRITE_COLLISION_FLAG_CLR_IN) | wr_refused;
      evt_d     = (evt_q & ~EVT_CLR_IN) | SLV_EVT_IN;
      sseen_d   = sseen_q;
      pseen_d   = pseen_q;
      if (start_evt) begin
         sseen_d = 1'b1;
         pseen_d = 1'b0;
      end
      if (stop_evt) begin
         pseen_d = 1'b1;
         sseen_d = 1'b0;
      end
      unique case (state_q)
         imba_pkg::ST_IDLE: begin
            if (stop_evt) begin
               evt_d = 1'b1;
            end
            if (START_REQ_IN) begin
               sen_d   = 1'b1;
               state_d = imba_pkg::ST_S_CHK;
            end else if (RESTART_REQ_IN) begin
               restart_enable_bit_d    = 1'b1;
               sda_drv_d = 1'b0;
               state_d   = imba_pkg::ST_R_REL;
            end else if (STOP_REQ_IN) begin
               pen_d     = 1'b1;
               sda_drv_d = 1'b1;
               state_d   = imba_pkg::ST_P_LO;
            end else if (ACK_REQ_IN) begin
               ack_sequence_enable_bit_d   = 1'b1;
               sda_drv_d = pull_for(ACK_DATA_IN);
               scl_drv_d = 1'b1;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_A_LO;
            end else if (wr_taken) begin
               shift_d   = BUF_DATA_IN;
               bit_d     = '0;
               bf_d      = 1'b1;
               sda_drv_d = pull_for(BUF_DATA_IN[DATA_W-1]);
               scl_drv_d = 1'b1;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_T_LO;
            end
         end
         imba_pkg::ST_S_CHK: begin
            if (~sda_s | ~scl_s) begin
               col = 1'b1;
            end else begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_C_HI;
            end
         end
         imba_pkg::ST_C_HI: begin
            if (~sda_s) begin
               sda_drv_d = 1'b1;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_C_LO;
            end else if (~scl_s) begin
               col = 1'b1;
            end else if (brg_zero) begin
               sda_drv_d = 1'b1;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_C_LO;
            end
         end
         imba_pkg::ST_C_LO: begin
            // SCL ignored here: another master may start just behind us
            if (brg_zero) begin
               scl_drv_d = 1'b1;
               sen_d     = 1'b0;
               restart_enable_bit_d    = 1'b0;
               evt_d     = 1'b1;
               state_d   = imba_pkg::ST_IDLE;
            end
         end
         imba_pkg::ST_R_REL: begin
            if (sda_s) begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_R_SCL;
            end
         end
         imba_pkg::ST_R_SCL: begin
            if (brg_zero) begin
               scl_drv_d = 1'b0;
               state_d   = imba_pkg::ST_R_WH;
            end
         end
         imba_pkg::ST_R_WH: begin
            if (scl_s & ~sda_s) begin
               col = 1'b1;
            end else if (scl_s) begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_C_HI;
            end
         end
         imba_pkg::ST_P_LO: begin
            if (~sda_s) begin
               scl_drv_d = 1'b0;
               state_d   = imba_pkg::ST_P_WH;
            end
         end
         imba_pkg::ST_P_WH: begin
            if (scl_s) begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_P_CNT;
            end
         end
         imba_pkg::ST_P_CNT: begin
            if (~scl_s) begin
               col = 1'b1;
            end else if (brg_zero) begin
               sda_drv_d = 1'b0;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_P_HI;
            end
         end
         imba_pkg::ST_P_HI: begin
            if (brg_zero & ~sda_s) begin
               col = 1'b1;
            end else if (brg_zero) begin
               pen_d   = 1'b0;
               evt_d   = 1'b1;
               state_d = imba_pkg::ST_IDLE;
            end
         end
         imba_pkg::ST_A_LO: begin
            if (brg_zero) begin
               scl_drv_d = 1'b0;
               state_d   = imba_pkg::ST_A_WH;
            end
         end
         imba_pkg::ST_A_WH: begin
            if (scl_s) begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_A_HI;
            end
         end
         imba_pkg::ST_A_HI: begin
            if (lost_arb) begin
               col = 1'b1;
            end else if (brg_zero) begin
               scl_drv_d = 1'b1;
               sda_drv_d = 1'b0;
               ack_sequence_enable_bit_d   = 1'b0;
               evt_d     = 1'b1;
               state_d   = imba_pkg::ST_IDLE;
            end
         end
         imba_pkg::ST_T_LO: begin
            if (brg_zero) begin
               scl_drv_d = 1'b0;
               state_d   = imba_pkg::ST_T_WH;
            end
         end
         imba_pkg::ST_T_WH: begin
            if (scl_s) begin
               brg_d   = RATE_RELOAD_IN;
               state_d = imba_pkg::ST_T_HI;
            end
         end
         imba_pkg::ST_T_HI: begin
            if (lost_arb & ~ack_slot) begin
               col = 1'b1;
            end else if (brg_zero & ack_slot) begin
               ackst_d   = sda_s;
               scl_drv_d = 1'b1;
               evt_d     = 1'b1;
               state_d   = imba_pkg::ST_IDLE;
            end else if (brg_zero) begin
               scl_drv_d = 1'b1;
               shift_d   = shift_next;
               bit_d     = bit_q + imba_pkg::BIT_W'(1);
               sda_drv_d = last_data ? 1'b0 : pull_for(shift_q[DATA_W-2]);
               bf_d      = bf_q & ~last_data;
               brg_d     = RATE_RELOAD_IN;
               state_d   = imba_pkg::ST_T_LO;
            end
         end
      endcase
      if (col) begin
         state_d   = imba_pkg::ST_IDLE;
         sda_drv_d = 1'b0;
         scl_drv_d = 1'b0;
         sen_d     = 1'b0;
         restart_enable_bit_d    = 1'b0;
         pen_d     = 1'b0;
         ack_sequence_enable_bit_d   = 1'b0;
         bf_d      = 1'b0;
      end
      bcol_d = (bcol_q & ~BCOL_CLR_IN) | col;
      if (~PORT_EN_IN) begin
         state_d   = imba_pkg::ST_IDLE;
         sda_drv_d = 1'b0;
         scl_drv_d = 1'b0;
         sen_d     = 1'b0;
         restart_enable_bit_d    = 1'b0;
         pen_d     = 1'b0;
         ack_sequence_enable_bit_d   = 1'b0;
         bf_d      = 1'b0;
         sseen_d   = 1'b0;
         pseen_d   = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sda_sync_q <= 2'h3;
         scl_sync_q <= 2'h3;
         stt_sync_q <= 3'h0;
         stp_sync_q <= 3'h0;
         port_en_q  <= 1'b0;
      end else begin
         sda_sync_q <= {sda_sync_q[0], SDA_IN};
         scl_sync_q <= {scl_sync_q[0], SCL_IN};
         stt_sync_q <= {stt_sync_q[1:0], mon_bus.start_tgl};
         stp_sync_q <= {stp_sync_q[1:0], mon_bus.stop_tgl};
         port_en_q  <= PORT_EN_IN;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_q   <= imba_pkg::ST_IDLE;
         brg_q     <= imba_pkg::RELOAD_RST;
         shift_q   <= imba_pkg::BUF_RST;
         bit_q     <= '0;
         sda_drv_q <= 1'b0;
         scl_drv_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         brg_q     <= brg_d;
         shift_q   <= shift_d;
         bit_q     <= bit_d;
         sda_drv_q <= sda_drv_d;
         scl_drv_q <= scl_drv_d;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         {sen_q, restart_enable_bit_q, pen_q, ack_sequence_enable_bit_q} <= 4'h0;
         {bf_q, ackst_q, write_collision_flag_q, bcol_q} <= 4'h0;
         {evt_q, sseen_q, pseen_q}       <= 3'h0;
         wake_q       <= 1'b0;
         idle_q       <= 1'b1;
         drive_zero_q <= 1'b0;
      end else begin
         {sen_q, restart_enable_bit_q, pen_q, ack_sequence_enable_bit_q} <= {sen_d, restart_enable_bit_d, pen_d, ack_sequence_enable_bit_d};
         {bf_q, ackst_q, write_collision_flag_q, bcol_q} <= {bf_d, ackst_d, write_collision_flag_d, bcol_d};
         {evt_q, sseen_q, pseen_q}       <= {evt_d, sseen_d, pseen_d};
         wake_q       <= SLEEP_IN & EVT_IE_IN & SLV_EVT_IN;
         idle_q       <= (state_d == imba_pkg::ST_IDLE);
         drive_zero_q <= 1'b0;
      end
   end

   assign SDA_OUT        = drive_zero_q;
   assign SCL_OUT        = drive_zero_q;
   assign SDA_OE_OUT     = sda_drv_q;
   assign SCL_OE_OUT     = scl_drv_q;
   assign START_EN_OUT   = sen_q;
   assign RESTART_EN_OUT = restart_enable_bit_q;
   assign STOP_EN_OUT    = pen_q;
   assign ACK_EN_OUT     = ack_sequence_enable_bit_q;
   assign BUF_FULL_OUT   = bf_q;
   assign ACK_STAT_OUT   = ackst_q;
   assign WRITE_COL_OUT  = write_collision_flag_q;
   assign BUS_COL_OUT    = bcol_q;
   assign SERIAL_EVT_OUT = evt_q;
   assign START_SEEN_OUT = sseen_q;
   assign STOP_SEEN_OUT  = pseen_q;
   assign WAKE_OUT       = wake_q;
   assign IDLE_OUT       = idle_q;
endmodule

/* imba_pkg.sv */
package imba_pkg;
   localparam int RATE_W = 8;
   localparam int DATA_W = 8;
   localparam int BIT_W  = 4;
   // Bit index of the acknowledge slot after eight data bits
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // Index of the last data bit; buffer empties after it
   localparam logic [3:0] LAST_DATA = 4'h7;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [7:0] BUF_RST = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE,
      ST_S_CHK,
      ST_C_HI,
      ST_C_LO,
      ST_R_REL,
      ST_R_SCL,
      ST_R_WH,
      ST_P_LO,
      ST_P_WH,
      ST_P_CNT,
      ST_P_HI,
      ST_A_LO,
      ST_A_WH,
      ST_A_HI,
      ST_T_LO,
      ST_T_WH,
      ST_T_HI
   } imba_state_t;
endpackage

/* imba_mon_if.sv */
`timescale 1ns/1ps
interface imba_mon_if;
   logic port_en;
   logic start_tgl;
   logic stop_tgl;

   modport ctl (output port_en, input start_tgl, input stop_tgl);
   modport mon (input port_en, output start_tgl, output stop_tgl);
endinterface

/* imba_bus_monitor.sv */
`timescale 1ns/1ps
// Watches the bus on the link clock and reports Start and Stop
// conditions as toggles for the system clock domain.
module imba_bus_monitor (
   input  wire logic link_clk_in, // Link sampling clock
   input  wire logic rst_in,      // Async reset, active high
   input  wire logic sda_in,      // Data line level
   input  wire logic scl_in,      // Clock line level
   imba_mon_if.mon   mon          // Toggles to the controller
);
   logic [1:0] sda_sync_q;
   logic [1:0] scl_sync_q;
   logic [1:0] en_sync_q;
   logic       sda_prev_q;
   logic       start_tgl_q;
   logic       stop_tgl_q;
   wire        sda_now = sda_sync_q[1];
   wire        scl_now = scl_sync_q[1];
   wire        armed   = en_sync_q[1] & scl_now;
   wire        start_hit = armed & sda_prev_q & ~sda_now;
   wire        stop_hit  = armed & ~sda_prev_q & sda_now;

   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sda_sync_q <= 2'h3;
         scl_sync_q <= 2'h3;
         en_sync_q  <= 2'h0;
         sda_prev_q <= 1'b1;
      end else begin
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_sync_q <= {scl_sync_q[0], scl_in};
         en_sync_q  <= {en_sync_q[0], mon.port_en};
         sda_prev_q <= sda_now;
      end
   end

   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_tgl_q <= 1'b0;
         stop_tgl_q  <= 1'b0;
      end else begin
         start_tgl_q <= start_tgl_q ^ start_hit;
         stop_tgl_q  <= stop_tgl_q ^ stop_hit;
      end
   end

   assign mon.start_tgl = start_tgl_q;
   assign mon.stop_tgl  = stop_tgl_q;
endmodule

/* imba_master_properties.sv */
`timescale 1ns/1ps
module imba_master_properties (
   input wire logic CLOCK_IN,       // Clock
   input wire logic RST_IN,         // Reset
   input wire logic SDA_IN,         // Data
   input wire logic SDA_OE_OUT,     // Data pull
   input wire logic SCL_OE_OUT,     // Clock pull
   input wire logic PORT_EN_IN,     // Enable
   input wire logic START_REQ_IN,   // Start
   input wire logic BUF_WR_IN,      // Write
   input wire logic BCOL_CLR_IN,    // Clear
   input wire logic SLEEP_IN,       // Asleep
   input wire logic EVT_IE_IN,      // Irq on
   input wire logic SLV_EVT_IN,     // Slave
   input wire logic START_EN_OUT,   // Start
   input wire logic RESTART_EN_OUT, // Restart
   input wire logic STOP_EN_OUT,    // Stop
   input wire logic ACK_EN_OUT,     // Ack
   input wire logic BUF_FULL_OUT,   // Full
   input wire logic WRITE_COL_OUT,  // Write col
   input wire logic BUS_COL_OUT,    // Bus col
   input wire logic SERIAL_EVT_OUT, // Event
   input wire logic START_SEEN_OUT, // Start seen
   input wire logic STOP_SEEN_OUT,  // Stop seen
   input wire logic WAKE_OUT,       // Wake
   input wire logic IDLE_OUT        // Idle
);
   default clocking dc @(posedge CLOCK_IN);
   endclocking
   default disable iff (RST_IN);
   // Data held low by another party with both own pulls off
   sequence s_sda_stuck;
      (!SDA_IN && !SDA_OE_OUT && !SCL_OE_OUT) [*6];
   endsequence
   sequence s_en_steady;
      PORT_EN_IN && $past(PORT_EN_IN) && !BUS_COL_OUT;
   endsequence
   a_col_frees: assert property (
      $rose(BUS_COL_OUT) |-> !SDA_OE_OUT && !SCL_OE_OUT && !BUF_FULL_OUT
      && !(START_EN_OUT || RESTART_EN_OUT || STOP_EN_OUT || ACK_EN_OUT))
      else $error("collision left a line or sequence active");
   a_bcol_sticky: assert property (
      BUS_COL_OUT && !BCOL_CLR_IN |=> BUS_COL_OUT)
      else $error("bus collision flag lost");
   a_write_collision_flag_busy: assert property (
      BUF_WR_IN && !IDLE_OUT && PORT_EN_IN |=> WRITE_COL_OUT)
      else $error("busy write not flagged");
   a_seen_clear: assert property (
      !PORT_EN_IN [*2] |-> !START_SEEN_OUT && !STOP_SEEN_OUT)
      else $error("seen flags kept while disabled");
   a_wake_cause: assert property (
      SLEEP_IN && EVT_IE_IN && SLV_EVT_IN |=> WAKE_OUT)
      else $error("no wake on slave event");
   a_start_abort: assert property (
      s_sda_stuck ##0 START_REQ_IN && IDLE_OUT && PORT_EN_IN
      |-> ##[1:8] BUS_COL_OUT) else $error("start on low data");
   a_start_done: assert property (
      $fell(START_EN_OUT) ##0 s_en_steady
      |-> SDA_OE_OUT && SCL_OE_OUT && SERIAL_EVT_OUT)
      else $error("start ended without both lines low");
   a_stop_done: assert property (
      $fell(STOP_EN_OUT) ##0 s_en_steady
      |-> SERIAL_EVT_OUT ##[0:4] STOP_SEEN_OUT)
      else $error("stop ended without event and stop seen");
endmodule
bind imba_master imba_master_properties chk_u (.*);

/* imba_bus_party.sv */
`timescale 1ns/1ps
// Another party on the wires; pulls a line low on command
module imba_bus_party (
   input  wire logic link_clk_in,  // Link clock
   input  wire logic rst_in,       // Reset
   input  wire logic sda_hold_in,  // Pull data
   input  wire logic scl_hold_in,  // Pull clock
   output logic      sda_pull_out, // Data low
   output logic      scl_pull_out  // Clock low
);
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sda_pull_out <= 1'b0;
         scl_pull_out <= 1'b0;
      end else begin
         sda_pull_out <= sda_hold_in;
         scl_pull_out <= scl_hold_in;
      end
   end
endmodule

/* imba_master_tb.sv */
`timescale 1ns/1ps
module imba_master_tb;
   logic       CLOCK_IN = 1'b0;
   logic       LINK_CLK_IN = 1'b0;
   logic       RST_IN = 1'b1;
   logic       PORT_EN_IN, START_REQ_IN, RESTART_REQ_IN, STOP_REQ_IN;
   logic       ACK_REQ_IN, ACK_DATA_IN, BUF_WR_IN, EVT_CLR_IN, WRITE_COLLISION_FLAG_CLR_IN;
   logic       BCOL_CLR_IN, SLEEP_IN, EVT_IE_IN, SLV_EVT_IN, sda_h, scl_h;
   logic [7:0] RATE_RELOAD_IN, BUF_DATA_IN, d;
   logic       SDA_IN, SDA_OUT, SDA_OE_OUT, SCL_IN, SCL_OUT, SCL_OE_OUT;
   logic       START_EN_OUT, RESTART_EN_OUT, STOP_EN_OUT, ACK_EN_OUT;
   logic       BUF_FULL_OUT, ACK_STAT_OUT, WRITE_COL_OUT, BUS_COL_OUT;
   logic       SERIAL_EVT_OUT, START_SEEN_OUT, STOP_SEEN_OUT, WAKE_OUT;
   logic       IDLE_OUT, sda_p, scl_p;
   logic [8:0] bits_q = 9'h000;
   int         miscompares = 0;
   int         check_count = 0;
   always #50 CLOCK_IN = ~CLOCK_IN;
   always #3 LINK_CLK_IN = ~LINK_CLK_IN;
   // Open drain with pull-ups
   assign SDA_IN = !(SDA_OE_OUT || sda_p);
   assign SCL_IN = !(SCL_OE_OUT || scl_p);
   always @(posedge SCL_IN) bits_q <= {bits_q[7:0], SDA_IN};
   imba_master dut_u (.*);
   imba_bus_party party_u (
      .link_clk_in  (LINK_CLK_IN),
      .rst_in       (RST_IN),
      .sda_hold_in  (sda_h),
      .scl_hold_in  (scl_h),
      .sda_pull_out (sda_p),
      .scl_pull_out (scl_p)
   );
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bits: start restart stop ack evtclr wcolclr bcolclr write
   task automatic pulse(input logic [7:0] r, input logic [7:0] v = 8'h00);
      @(posedge CLOCK_IN);
      {START_REQ_IN, RESTART_REQ_IN, STOP_REQ_IN, ACK_REQ_IN} <= r[7:4];
      {EVT_CLR_IN, WRITE_COLLISION_FLAG_CLR_IN, BCOL_CLR_IN, BUF_WR_IN} <= r[3:0];
      BUF_DATA_IN <= v;
      @(posedge CLOCK_IN);
      {START_REQ_IN, RESTART_REQ_IN, STOP_REQ_IN, ACK_REQ_IN} <= 4'h0;
      {EVT_CLR_IN, WRITE_COLLISION_FLAG_CLR_IN, BCOL_CLR_IN, BUF_WR_IN} <= 4'h0;
   endtask
   task automatic settle();
      int n;
      n = 0;
      repeat (2) @(negedge CLOCK_IN);
      while (!(IDLE_OUT === 1'b1 && (SERIAL_EVT_OUT | BUS_COL_OUT) === 1'b1)
             && n < 3000) begin
         @(negedge CLOCK_IN);
         n++;
      end
      if (n == 3000) miscompares++;
   endtask
   task automatic xfer(input logic [7:0] v);
      pulse(8'h09, v);
      settle();
      chk(bits_q, {v, 1'b1});
      chk(ACK_STAT_OUT, 1'b1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      {PORT_EN_IN, START_REQ_IN, RESTART_REQ_IN, STOP_REQ_IN, ACK_REQ_IN,
       ACK_DATA_IN, BUF_WR_IN, EVT_CLR_IN, WRITE_COLLISION_FLAG_CLR_IN, BCOL_CLR_IN,
       SLEEP_IN, EVT_IE_IN, SLV_EVT_IN, sda_h, scl_h} = 15'h4000;
      BUF_DATA_IN = 8'h00;
      void'($urandom(32'h8fad));
      RATE_RELOAD_IN = 8'($urandom_range(12, 3));
      repeat (3) @(posedge CLOCK_IN);
      @(negedge CLOCK_IN);
      chk({IDLE_OUT, SDA_OE_OUT, SCL_OE_OUT, BUS_COL_OUT, START_SEEN_OUT,
           STOP_SEEN_OUT, SDA_OUT, SCL_OUT}, 9'h080);
      @(posedge CLOCK_IN);
      RST_IN <= 1'b0;
      repeat (3) @(posedge CLOCK_IN);
      $display("reset test done");
      pulse(8'h80);
      settle();
      chk({SDA_OE_OUT, SCL_OE_OUT, START_EN_OUT, BUS_COL_OUT,
           START_SEEN_OUT}, 9'h019);
      d = 8'($urandom());
      pulse(8'h08);
      xfer(d);
      @(posedge CLOCK_IN);
      ACK_DATA_IN <= 1'($urandom());
      pulse(8'h18);
      settle();
      chk({bits_q[0], ACK_EN_OUT}, {ACK_DATA_IN, 1'b0});
      pulse(8'h28);
      pulse(8'h01, ~d);
      settle();
      repeat (4) @(negedge CLOCK_IN);
      chk({WRITE_COL_OUT, STOP_SEEN_OUT, STOP_EN_OUT, SDA_OE_OUT,
           SCL_OE_OUT}, 9'h018);
      $display("start byte ack stop test done");
      pulse(8'h8e);
      settle();
      sda_h = 1'b1;
      pulse(8'h09, 8'hff);
      settle();
      chk({BUS_COL_OUT, BUF_FULL_OUT, SDA_OE_OUT, SCL_OE_OUT,
           IDLE_OUT}, 9'h011);
      pulse(8'h08);
      sda_h = 1'b0;
      repeat (20) @(negedge CLOCK_IN);
      chk({SERIAL_EVT_OUT, STOP_SEEN_OUT, BUS_COL_OUT}, 9'h007);
      pulse(8'h8a);
      settle();
      chk(BUS_COL_OUT, 1'b0);
      pulse(8'h08);
      xfer(8'($urandom()));
      pulse(8'h48);
      settle();
      chk({SDA_OE_OUT, SCL_OE_OUT, RESTART_EN_OUT, BUS_COL_OUT}, 9'h00c);
      pulse(8'h28);
      settle();
      $display("collision and restart test done");
      for (int k = 0; k < 2; k++) begin
         {sda_h, scl_h} = k ? 2'b01 : 2'b10;
         repeat (10) @(negedge CLOCK_IN);
         pulse(8'h8a);
         settle();
         chk({BUS_COL_OUT, START_EN_OUT, IDLE_OUT, SDA_OE_OUT}, 9'h00a);
         {sda_h, scl_h} = 2'b00;
         repeat (20) @(negedge CLOCK_IN);
      end
      @(posedge CLOCK_IN);
      PORT_EN_IN <= 1'b0;
      repeat (3) @(negedge CLOCK_IN);
      chk({START_SEEN_OUT, STOP_SEEN_OUT}, 9'h000);
      @(posedge CLOCK_IN);
      PORT_EN_IN <= 1'b1;
      {SLEEP_IN, EVT_IE_IN} <= 2'b11;
      @(posedge CLOCK_IN);
      SLV_EVT_IN <= 1'b1;
      @(posedge CLOCK_IN);
      SLV_EVT_IN <= 1'b0;
      @(negedge CLOCK_IN);
      chk({WAKE_OUT, SERIAL_EVT_OUT}, 9'h003);
      $display("disable and wake test done");
      summarize();
   end
   // Tests need far fewer than 30000 cycles
   initial begin
      #(100 * 30000);
      miscompares++;
      summarize();
   end
endmodule
